/* verilog/acr_regs.sv */
// Compare value, compare control and two conversion result registers.
// Assumes the converter core gives one-cycle store strobes with result data on pclk.
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
module acr_regs (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Converter core
   input wire logic store_0,
   input wire logic [11:0] store_data_0,
   input wire logic store_1,
   input wire logic [11:0] store_data_1,
   // Compare result
   output logic compare_match
);

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
      hit = (addr == off);
   endfunction

   function automatic acr_pkg::acr_result_type next_result(input acr_pkg::acr_result_type cur,
         input logic store, input logic [11:0] data, input logic rd_clear);
      next_result = cur;
      if (rd_clear) begin
         next_result.overrun = 1'b0;
         next_result.stored = 1'b0;
      end
      // Store wins over a clearing read in the same cycle
      if (store) begin
         next_result.value = data;
         next_result.stored = 1'b1;
         next_result.overrun = cur.stored;
      end
   endfunction

   function automatic logic [31:0] result_word(input acr_pkg::acr_result_type r);
      result_word = acr_pkg::RESET_WORD;
      result_word[acr_pkg::DATA_MSB:acr_pkg::DATA_LSB] = r.value;
      result_word[acr_pkg::OVERRUN_BIT] = r.overrun;
      result_word[acr_pkg::STORED_BIT] = r.stored;
   endfunction

   logic [11:0] compare_value_1;
   acr_pkg::acr_control_type compare_control_1;
   acr_pkg::acr_result_type conversion_result_0;
   acr_pkg::acr_result_type conversion_result_1;
   acr_pkg::acr_result_type next_conversion_result_0;
   acr_pkg::acr_result_type next_conversion_result_1;

   wire access = psel && penable;
   wire wr = access && pwrite;
   wire rd = access && !pwrite;
   wire hit_cmp = hit(paddr, acr_pkg::OFF_COMPARE_VALUE_1);
   wire hit_r0 = hit(paddr, acr_pkg::OFF_CONVERSION_RESULT_0);
   wire hit_r1 = hit(paddr, acr_pkg::OFF_CONVERSION_RESULT_1);
   wire hit_ctl = hit(paddr, acr_pkg::OFF_COMPARE_CONTROL_1);
   wire mapped = hit_cmp || hit_r0 || hit_r1 || hit_ctl;
   // Only a read with pstrb[0] set or with pstrb all zero clears the flags
   wire rd_clear_0 = rd && hit_r0 && pstrb[0] || rd && hit_r0 && (pstrb == 4'h0);
   wire rd_clear_1 = rd && hit_r1 && pstrb[0] || rd && hit_r1 && (pstrb == 4'h0);
   wire wr_cmp = wr && hit_cmp;
   wire wr_ctl = wr && hit_ctl;

   assign pready = 1'b1;
   assign pslverr = access && !mapped;

   // ----------------------------------------------------------------
   // Compare value and control
   // ----------------------------------------------------------------
   wire [11:0] next_compare_value_1 = wr_cmp && pstrb[0] && pstrb[1]
         ? pwdata[acr_pkg::DATA_MSB:acr_pkg::DATA_LSB] : compare_value_1;
   wire [5:0] ctl_bits = {pwdata[acr_pkg::MON_EN_BIT], pwdata[acr_pkg::DIR_BIT],
         pwdata[acr_pkg::SEL_MSB:0]};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_value_1 <= '0;
         compare_control_1 <= '0;
      end else begin
         compare_value_1 <= next_compare_value_1;
         if (wr_ctl && pstrb[0]) begin
            compare_control_1 <= acr_pkg::acr_control_type'(ctl_bits);
         end
      end
   end

   // ----------------------------------------------------------------
   // Result registers
   // ----------------------------------------------------------------
   always_comb begin
      next_conversion_result_0 = next_result(conversion_result_0, store_0, store_data_0,
            rd_clear_0);
      next_conversion_result_1 = next_result(conversion_result_1, store_1, store_data_1,
            rd_clear_1);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conversion_result_0 <= '0;
         conversion_result_1 <= '0;
      end else begin
         conversion_result_0 <= next_conversion_result_0;
         conversion_result_1 <= next_conversion_result_1;
      end
   end

   // ----------------------------------------------------------------
   // Compare
   // ----------------------------------------------------------------
   logic [11:0] sel_value;
   logic sel_valid;
   logic next_compare_match;
   always_comb begin
      sel_value = '0;
      sel_valid = 1'b0;
      if (compare_control_1.source == acr_pkg::SEL_RESULT_0) begin
         sel_value = conversion_result_0.value;
         sel_valid = 1'b1;
      end else if (compare_control_1.source == acr_pkg::SEL_RESULT_1) begin
         sel_value = conversion_result_1.value;
         sel_valid = 1'b1;
      end
      next_compare_match = 1'b0;
      if (compare_control_1.monitor_enable && sel_valid) begin
         if (compare_control_1.direction == acr_pkg::DIR_GREATER_EQUAL) begin
            next_compare_match = sel_value >= compare_value_1;
         end else begin
            next_compare_match = sel_value <= compare_value_1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_match <= 1'b0;
      end else begin
         compare_match <= next_compare_match;
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   logic [31:0] next_prdata;
   always_comb begin
      next_prdata = acr_pkg::RESET_WORD;
      if (hit_cmp) begin
         next_prdata[acr_pkg::DATA_MSB:acr_pkg::DATA_LSB] = compare_value_1;
      end else if (hit_r0) begin
         next_prdata = result_word(conversion_result_0);
      end else if (hit_r1) begin
         next_prdata = result_word(conversion_result_1);
      end else if (hit_ctl) begin
         next_prdata[acr_pkg::MON_EN_BIT] = compare_control_1.monitor_enable;
         next_prdata[acr_pkg::DIR_BIT] = compare_control_1.direction;
         next_prdata[acr_pkg::SEL_MSB:0] = compare_control_1.source;
      end
   end

   // Registered on the setup cycle so data stands at the access edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= next_prdata;
      end
   end

endmodule

/* include/acr_pkg.sv */
// Package for the converter result and compare register slice.
// Assumes a 32-bit APB slave on pclk with asynchronous active-low reset.
package acr_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] OFF_COMPARE_VALUE_1 = 12'h000;
   localparam logic [11:0] OFF_CONVERSION_RESULT_0 = 12'h004;
   localparam logic [11:0] OFF_CONVERSION_RESULT_1 = 12'h008;
   localparam logic [11:0] OFF_COMPARE_CONTROL_1 = 12'h00C;

   // ----------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------
   localparam int DATA_W = 12;
   localparam int DATA_LSB = 4;
   localparam int DATA_MSB = 15;
   localparam int OVERRUN_BIT = 1;
   localparam int STORED_BIT = 0;
   localparam int SEL_MSB = 3;
   localparam int DIR_BIT = 4;
   localparam int MON_EN_BIT = 7;
   localparam int SEL_W = 4;
   localparam logic [SEL_W-1:0] SEL_RESULT_0 = 4'h0;
   localparam logic [SEL_W-1:0] SEL_RESULT_1 = 4'h1;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {
      DIR_GREATER_EQUAL = 1'b0,
      DIR_LESS_EQUAL = 1'b1
   } acr_dir_type;

   typedef struct packed {
      logic [DATA_W-1:0] value;
      logic overrun;
      logic stored;
   } acr_result_type;

   typedef struct packed {
      logic monitor_enable;
      acr_dir_type direction;
      logic [SEL_W-1:0] source;
   } acr_control_type;

endpackage

/* test/acr_regs_assertions.sv */
// Checker for the result and compare register slice.
// Assumes bind to acr_regs; zero wait states, prdata loaded at setup.
module acr_regs_assertions (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic pready,
   // Converter core
   input wire logic store_0,
   input wire logic [11:0] store_data_0
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic rd = psel && penable && !pwrite;
   wire logic su4 = psel && !penable && !pwrite && paddr == 12'h004;
   // Only the four aligned word offsets are decoded
   wire logic known = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008 || paddr == 12'h00C;
   err_decode_a: assert property (psel && penable |-> pslverr == !known) else $error("bad pslverr");
   unmap_zero_a: assert property (rd && !known |-> prdata == 32'h0000_0000) else $error("bad read");
   ready_high_a: assert property (psel && penable |-> pready) else $error("wait state seen");
   upper_zero_a: assert property (rd |-> prdata[31:16] == 16'h0000) else $error("upper bits set");
   result_gap_a: assert property (rd && paddr[3] != paddr[2] |-> prdata[3:2] == 2'b00) else $error("gap set");
   cmp_gap_a: assert property (rd && paddr == 12'h000 |-> prdata[3:0] == 4'h0) else $error("gap set");
   store_seen_a: assert property (store_0 ##1 !store_0 && !psel ##1 su4 |=>
      prdata[15:4] == $past(store_data_0, 3) && prdata[0]) else $error("store lost");
   overrun_set_a: assert property (store_0 ##1 store_0 ##1 !psel ##1 su4 |=> prdata[1:0] == 2'b11)
      else $error("no overrun");
   flag_clear_a: assert property (rd && paddr == 12'h004 && !store_0 ##1 !store_0 ##1 su4 |=>
      prdata[1:0] == 2'b00) else $error("flags kept");
   cover property (rd && paddr == 12'h004 && prdata[1]);
   cover property (psel && penable && pslverr);
   cover property (store_0 ##1 store_0);
endmodule
bind acr_regs acr_regs_assertions chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr), .pready(pready),
   .store_0(store_0),
   .store_data_0(store_data_0));

/* test/acr_apb_master.sv */
// APB master model standing for the processor.
// Assumes the bench top is acr_regs_tb with give_verdict and num_errors.
module acr_apb_master (
   // Bus inputs
   input wire logic pclk,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   // Bus outputs
   output logic psel = 1'b0,
   output logic penable = 1'b0,
   output logic pwrite = 1'b0,
   output logic [11:0] paddr = 12'h000,
   output logic [31:0] pwdata = 32'h0000_0000,
   output logic [3:0] pstrb = 4'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= w ? 4'hF : 4'h0;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      r = prdata;
      e = pslverr;
      if (n >= 16) begin
         acr_regs_tb.num_errors++;
         acr_regs_tb.give_verdict();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

/* test/acr_regs_tb.sv */
// Self-checking bench for the result and compare register slice.
// Assumes the APB master model and the bound checker.
module acr_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, compare_match, err;
   logic store_0 = 1'b0;
   logic store_1 = 1'b0;
   logic [11:0] paddr;
   logic [11:0] store_data_0 = 12'h000;
   logic [11:0] store_data_1 = 12'h000;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   int num_errors = 0;
   int comparisons = 0;
   acr_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .store_0(store_0),
      .store_data_0(store_data_0), .store_1(store_1), .store_data_1(store_data_1), .compare_match(compare_match));
   acr_apb_master m (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
   initial forever #2.5 pclk = ~pclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] exp);
      m.xfer(1'b0, a, 32'h0000_0000, rd, err);
      chk(rd, exp);
   endtask
   task automatic put(input logic ch, input logic [11:0] d, input int n);
      @(posedge pclk);
      store_0 <= !ch;
      store_1 <= ch;
      store_data_0 <= d;
      store_data_1 <= d;
      repeat (n) @(posedge pclk);
      store_0 <= 1'b0;
      store_1 <= 1'b0;
   endtask
   task automatic mc(input logic [31:0] ctl, input logic exp);
      m.xfer(1'b1, 12'h00C, ctl, rd, err);
      repeat (2) @(posedge pclk);
      chk(32'(compare_match), 32'(exp));
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a < 16; a += 4) rc(12'(a), 32'h0000_0000);
      chk(32'(compare_match), 32'h0000_0000);
      $display("test reset done");
      m.xfer(1'b1, 12'h000, 32'hFFFF_FFFF, rd, err);
      rc(12'h000, 32'h0000_FFF0);
      m.xfer(1'b1, 12'h004, 32'hFFFF_FFFF, rd, err);
      rc(12'h004, 32'h0000_0000);
      put(1'b0, 12'hABC, 1);
      rc(12'h004, 32'h0000_ABC1);
      rc(12'h004, 32'h0000_ABC0);
      put(1'b0, 12'h5A5, 2);
      rc(12'h004, 32'h0000_5A53);
      put(1'b1, 12'h123, 1);
      rc(12'h008, 32'h0000_1231);
      rc(12'h008, 32'h0000_1230);
      rc(12'h004, 32'h0000_5A50);
      $display("test results done");
      chk(32'(err), 32'h0000_0000);
      m.xfer(1'b0, 12'h010, 32'h0000_0000, rd, err);
      chk(32'(err), 32'h0000_0001);
      chk(rd, 32'h0000_0000);
      $display("test unmapped done");
      m.xfer(1'b1, 12'h000, 32'h0000_8000, rd, err);
      mc(32'h0000_0080, 1'b0);
      mc(32'h0000_0090, 1'b1);
      mc(32'h0000_0091, 1'b1);
      put(1'b1, 12'hFFF, 1);
      repeat (2) @(posedge pclk);
      chk(32'(compare_match), 32'h0000_0000);
      mc(32'h0000_0081, 1'b1);
      $display("test compare done");
      give_verdict();
   end
endmodule
